// ==== bench/owt_otp_model.sv ====
/*
  Behavioural otp array: answers each read strobe with one valid pulse.
  Assumes strobes come from the loader on the same clock.
*/
`default_nettype none

// ==========================================================
// otp array model
module owt_otp_model (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic       otp_rd,
  input  wire logic [7:0] otp_addr,
  output logic      [7:0] otp_rdata,
  output logic            otp_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] addr_q = 8'h00;
  int         wait_q = 0;
  initial begin
    otp_rvalid = 1'b0;
    otp_rdata  = 8'h00;
  end
  // latency of two cycles, or five when slow; data not held past valid
  always @(posedge ref_clk) begin
    if (otp_rvalid) begin
      otp_rvalid <= 1'b0;
      otp_rdata  <= ~otp_rdata;
    end
    if (otp_rd) begin
      addr_q <= otp_addr;
      wait_q <= slow ? 4 : 1;
    end else if (wait_q == 1) begin
      otp_rvalid <= 1'b1;
      otp_rdata  <= addr_q ^ 8'h3C;
      wait_q     <= 0;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule

`default_nettype wire

// ==== bench/owt_window_sva.sv ====
/*
  Port checker for the otp window registers.
  Assumes one clock domain and the package constants.
*/
`default_nettype none

// ==========================================================
// checker
module owt_window_sva
  import owt_pkg::*;
#(
  parameter int RESULT_W = 16
) (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata_q,
  input wire logic                spi_mode,
  input wire logic                init_complete_lock,
  input wire logic                otp_rd_q,
  input wire logic [RESULT_W-1:0] sensor_result_zero,
  input wire logic [RESULT_W-1:0] tag0_data_q,
  input wire logic                tag0_err_q,
  input wire logic                wrap_en0_q,
  input wire logic                wrap_en1_q,
  input wire logic                load_busy_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  start_busy_a: assert property (reg_wr && !init_complete_lock && reg_addr == ADDR_SEL
    && reg_wdata[7:4] >= CODE_FIRST |-> ##2 load_busy_q) else $error("load did not start");
  load_bound_a: assert property ($rose(load_busy_q) |-> ##[1:510] !load_busy_q)
    else $error("load too long");
  stat_load_a: assert property (reg_rd && reg_addr == ADDR_STAT && load_busy_q
    |=> reg_rdata_q == BYTE_ZERO) else $error("status not zero in load");
  low_nibble_a: assert property (reg_rd && (reg_addr == ADDR_SEL || reg_addr == ADDR_STAT)
    |=> reg_rdata_q[3:0] == NIB_ZERO) else $error("low nibble not zero");
  read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved");
  lock_hold_a: assert property (!$past(rst) && init_complete_lock
    && $past(init_complete_lock) && !load_busy_q |=> !load_busy_q) else $error("load under lock");
  tag_route_a: assert property (spi_mode ##1 !tag0_err_q
    |-> tag0_data_q == $past(sensor_result_zero)) else $error("tag zero not routed");
  tag_quiet_a: assert property (!spi_mode |=> tag0_data_q == '0 && !tag0_err_q)
    else $error("tag active in i2c");
  wrap_off_a: assert property (spi_mode |=> !wrap_en0_q && !wrap_en1_q)
    else $error("wrap on in spi");
  otp_pulse_a: assert property (otp_rd_q |-> load_busy_q ##1 !otp_rd_q)
    else $error("stray otp strobe");
endmodule

bind owt_window_regs owt_window_sva #(.RESULT_W(RESULT_W)) sva_i (
  .ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_q, .spi_mode,
  .init_complete_lock, .otp_rd_q, .sensor_result_zero, .tag0_data_q, .tag0_err_q,
  .wrap_en0_q, .wrap_en1_q, .load_busy_q
);

`default_nettype wire

// ==== bench/test_otp_window_and_source_tags.sv ====
/*
  Self-checking bench for the otp window and source-tag registers.
  Assumes the otp model beside the design and a 10 MHz clock.
*/
`default_nettype none

// ==========================================================
// bench
module test_otp_window_and_source_tags
  import owt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst, reg_wr, reg_rd, spi_mode, init_complete_lock, slow;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, otp_addr_q, otp_rdata;
  logic        otp_rd_q, otp_rvalid, tag0_err_q, tag1_err_q, wrap_en0_q, wrap_en1_q;
  logic        load_busy_q, array_err_q;
  logic [15:0] sensor_result_zero, sensor_result_one, tag0_data_q, tag1_data_q;
  logic [3:0]  tag0_id_q, tag1_id_q;
  logic [7:0]  exp_q[$];
  int          fails = 0;
  int          checked = 0;

  owt_window_regs #(.RESULT_W(16)) dut (
    .ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_q, .spi_mode,
    .init_complete_lock, .otp_addr_q, .otp_rd_q, .otp_rdata, .otp_rvalid,
    .sensor_result_zero, .sensor_result_one, .tag0_data_q, .tag0_id_q, .tag0_err_q,
    .tag1_data_q, .tag1_id_q, .tag1_err_q, .wrap_en0_q, .wrap_en1_q, .load_busy_q,
    .array_err_q
  );
  owt_otp_model otp (.ref_clk, .slow, .otp_rd(otp_rd_q), .otp_addr(otp_addr_q), .otp_rdata,
    .otp_rvalid);

  // clock at 100 ns
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_wr    = 1'b0;
  endtask

  // read noted in the queue, compared by the watcher
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk) #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge ref_clk) #1;
    reg_rd   = 1'b0;
  endtask

  // wait out a load, bounded
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(posedge ref_clk);
    while (load_busy_q !== 1'b0 && n < 600) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 600)
      chk(16'h0001, 16'h0000);
  endtask

  // watcher: one result per sampled read strobe
  always @(posedge ref_clk) begin
    if (reg_rd === 1'b1) begin
      #2;
      chk({8'h00, reg_rdata_q}, exp_q.pop_front());
    end
  end

  // hang guard
  initial begin
    int cyc;
    cyc = 0;
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 10000) begin
        fails++;
        close_out();
      end
    end
  end

  initial begin
    logic [7:0] v;
    logic [3:0] n;
    v = 8'($urandom(43));
    {rst, reg_wr, reg_rd, spi_mode, init_complete_lock, slow} = 6'h20;
    {reg_addr, reg_wdata, sensor_result_zero, sensor_result_one} = '0;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    settle();
    rd(ADDR_SEL, SEL_RST);
    rd(ADDR_STAT, STAT_RST);
    rd(8'hE5, 8'hE5 ^ 8'h3C);
    // every range code, fast and slow otp
    // reads of one region end before the next select
    for (int c = 10; c < 16; c++) begin
      slow = c[0];
      n = 4'(c);
      wr(ADDR_SEL, {n, 4'h0});
      rd(ADDR_STAT, BYTE_ZERO);
      settle();
      rd(ADDR_STAT, {n, 4'h0});
      v = 8'($urandom()) | 8'hA0;
      rd(v, {n, v[3:0]} ^ 8'h3C);
    end
    // reserved and empty codes load nothing
    for (int c = 0; c < 10; c++) begin
      n = 4'(c);
      wr(ADDR_SEL, {n, 4'h0});
      repeat (3) @(posedge ref_clk);
      #1;
      chk({15'h0, load_busy_q}, 16'h0);
      rd(ADDR_SEL, {n, 4'h0});
      rd(ADDR_STAT, 8'hF0);
      rd(8'hB7, 8'hF7 ^ 8'h3C);
    end
    wr(ADDR_STAT, 8'h55);
    rd(ADDR_STAT, 8'hF0);
    v = 8'($urandom());
    wr(8'hF3, v);
    rd(ADDR_STAT, {CODE_OVERWR, 4'h0});
    rd(8'hD3, v);
    init_complete_lock = 1'b1;
    wr(ADDR_SEL, 8'hB0);
    wr(ADDR_TAG0, 8'hFF);
    wr(8'hF4, 8'h00);
    rd(ADDR_SEL, 8'h90);
    rd(ADDR_TAG0, TAG_RST);
    rd(8'hF4, 8'hF4 ^ 8'h3C);
    init_complete_lock = 1'b0;
    v = 8'($urandom()) | 8'h80;
    n = 4'($urandom());
    wr(ADDR_TAG0, v);
    wr(ADDR_TAG1, {4'h0, n});
    spi_mode = 1'b1;
    sensor_result_zero = 16'($urandom());
    sensor_result_one = 16'($urandom());
    repeat (3) @(posedge ref_clk);
    #1;
    chk(tag0_data_q, sensor_result_zero);
    chk({12'h0, tag0_id_q}, {12'h0, v[3:0]});
    chk({14'h0, tag0_err_q, tag1_err_q}, 16'h0001);
    chk({12'h0, tag1_id_q}, {12'h0, n});
    chk(tag1_data_q, 16'h0000);
    spi_mode = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({14'h0, wrap_en0_q, wrap_en1_q}, 16'h0002);
    chk(tag0_data_q | {12'h0, tag0_id_q}, 16'h0);
    rd(ADDR_TAG0, v);
    rd(ADDR_TAG1, {4'h0, n});
    rd(8'h30, BYTE_ZERO);
    chk({15'h0, array_err_q}, 16'h0);
    repeat (3) @(posedge ref_clk);
    close_out();
  end
endmodule

`default_nettype wire

// ==== rtl/owt_otp_loader.sv ====
/*
  Copies sixteen otp bytes of one range into the shared window.
  Assumes an otp read port that answers each read strobe with a valid pulse.
*/
`default_nettype none

module owt_otp_loader
  import owt_pkg::*;
(
  input  wire  logic       ref_clk,
  input  wire  logic       rst,
  input  wire  logic       start,
  input  wire  logic [3:0] code,
  input  wire  logic [7:0] otp_rdata,
  input  wire  logic       otp_rvalid,
  output logic       [7:0] otp_addr_q,
  output logic             otp_rd_q,
  output logic             win_we,
  output logic       [3:0] win_idx,
  output logic       [7:0] win_data,
  output logic             busy,
  output logic             done,
  output logic             fail
);

  typedef enum logic [1:0] {OWT_IDLE, OWT_REQ, OWT_WAIT} owt_ld_state_t;

  localparam logic [9:0] WD_LAST = 10'(LOAD_MAX_CYC - 1);

  owt_ld_state_t state_q;
  logic [3:0]    idx_q;
  logic [3:0]    base_q;
  logic [9:0]    wd_q;
  logic          wd_hit;

  assign wd_hit   = (wd_q == WD_LAST);
  assign busy     = (state_q != OWT_IDLE);
  assign win_we   = (state_q == OWT_WAIT) && otp_rvalid;
  assign win_idx  = idx_q;
  assign win_data = otp_rdata;
  assign done     = win_we && (idx_q == IDX_LAST);
  assign fail     = busy && wd_hit && !done && !start;

  // ==========================================================
  // sequence: one read per window word, restart on new start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q    <= OWT_IDLE;
      idx_q      <= NIB_ZERO;
      base_q     <= NIB_ZERO;
      otp_rd_q   <= 1'b0;
      otp_addr_q <= BYTE_ZERO;
    end else if (start) begin
      state_q <= OWT_REQ;
      idx_q   <= NIB_ZERO;
      base_q  <= code;
      otp_rd_q <= 1'b0;
    end else begin
      otp_rd_q <= 1'b0;
      case (state_q)
        OWT_IDLE: begin
          idx_q <= NIB_ZERO;
        end
        OWT_REQ: begin
          otp_rd_q   <= 1'b1;
          otp_addr_q <= {base_q, idx_q};
          state_q    <= OWT_WAIT;
        end
        OWT_WAIT: begin
          if (wd_hit) begin
            state_q <= OWT_IDLE;        // give up, status stays loading unless the last word arrives this cycle
          end else if (otp_rvalid) begin
            if (idx_q == IDX_LAST) begin
              state_q <= OWT_IDLE;
            end else begin
              idx_q   <= idx_q + 4'h1;
              state_q <= OWT_REQ;
            end
          end
        end
        default: state_q <= OWT_IDLE;
      endcase
    end
  end

  // watchdog bounding one whole load
  always_ff @(posedge ref_clk) begin
    if (rst || start || !busy) begin
      wd_q <= 10'h000;
    end else if (!wd_hit) begin
      wd_q <= wd_q + 10'h001;
    end
  end

  initial begin
    if (LOAD_MAX_CYC < 3 * WIN_WORDS || LOAD_MAX_CYC > 1023) begin
      $error("load time does not fit the watchdog");
    end
  end

endmodule

`default_nettype wire

// ==== rtl/owt_pkg.sv ====
/*
  Constants shared by the OTP window register logic and its loader.
  Assumes an 8-bit register address space and a 10 MHz system clock.
*/
`default_nettype none

package owt_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_SEL  = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h15;
  localparam logic [7:0] ADDR_TAG0 = 8'h1A;
  localparam logic [7:0] ADDR_TAG1 = 8'h1B;

  // ==========================================================
  // field layout and reset values
  localparam int         CODE_LSB    = 4;
  localparam int         CODE_MSB    = 7;
  localparam int         TAG_EN_BIT  = 7;
  localparam int         TAG_ID_MSB  = 3;
  localparam logic [7:0] SEL_RST     = 8'hE0;
  localparam logic [7:0] STAT_RST    = 8'hE0;
  localparam logic [7:0] TAG_RST     = 8'h00;
  localparam logic [3:0] CODE_LOAD   = 4'h0;
  localparam logic [3:0] CODE_OVERWR = 4'h1;
  localparam logic [3:0] CODE_FIRST  = 4'hA;
  localparam logic [3:0] NIB_ZERO    = 4'h0;
  localparam logic [3:0] IDX_LAST    = 4'hF;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam int         WIN_WORDS   = 16;

  // ==========================================================
  // timing: the load must finish inside the host's wait
  localparam int LOAD_MAX_US  = 50;
  localparam int CLK_MHZ      = 10;
  localparam int LOAD_MAX_CYC = LOAD_MAX_US * CLK_MHZ;

  // ==========================================================
  // helpers
  // true for a code that names one 16-address otp range
  function automatic logic is_range_code(input logic [3:0] code);
    return code >= CODE_FIRST;
  endfunction

  // even parity of one stored byte
  function automatic logic par8(input logic [7:0] v);
    return ^v;
  endfunction

endpackage

`default_nettype wire

// ==== rtl/owt_window_regs.sv ====
/*
  Otp window select/status registers, the shared 16-byte window and the
  two source-tag registers with their channel routing.
  Assumes a same-clock register port from the serial front end, an otp read
  port, and mode and lock levels from logic on the same clock.
*/
// Behaviour
// - six otp regions share one sixteen-register readable window.
// - codes A..F load A0h..FFh; 2..9 reserved; 0,1 select nothing.
// - status field reads zero while a load is copying.
// - status reads 0001 after the user overwrites the window.
// - finished load shows its code in status, matching the request.
// - any otp address reads window word of its low nibble.
// - no error for reading outside the loaded range.
// - with lock set all writes here are ignored.
// - after lock only the region loaded at locking stays readable.
// - status register is read-only; writes leave it unchanged.
// - select and status take part in array error detection.
// - two tag registers, enable bit and tag code, error checked.
// - spi mode, enabled tag carries its matching sensor result.
// - spi mode, disabled tag carries the spi error response.
// - i2c mode, enable bits set read wrap-around.
// - i2c mode, tag codes stay read/write but do nothing.
`default_nettype none

module owt_window_regs
  import owt_pkg::*;
#(
  parameter int RESULT_W = 16
) (
  input  wire  logic                ref_clk,
  input  wire  logic                rst,
  // register port
  input  wire  logic [7:0]          reg_addr,
  input  wire  logic                reg_wr,
  input  wire  logic [7:0]          reg_wdata,
  input  wire  logic                reg_rd,
  output logic       [7:0]          reg_rdata_q,
  // device mode and lock
  input  wire  logic                spi_mode,
  input  wire  logic                init_complete_lock,
  // otp array read port
  output logic       [7:0]          otp_addr_q,
  output logic                      otp_rd_q,
  input  wire  logic [7:0]          otp_rdata,
  input  wire  logic                otp_rvalid,
  // sensor results and tag channels
  input  wire  logic [RESULT_W-1:0] sensor_result_zero,
  input  wire  logic [RESULT_W-1:0] sensor_result_one,
  output logic       [RESULT_W-1:0] tag0_data_q,
  output logic       [3:0]          tag0_id_q,
  output logic                      tag0_err_q,
  output logic       [RESULT_W-1:0] tag1_data_q,
  output logic       [3:0]          tag1_id_q,
  output logic                      tag1_err_q,
  output logic                      wrap_en0_q,
  output logic                      wrap_en1_q,
  // status
  output logic                      load_busy_q,
  output logic                      array_err_q
);

  // ==========================================================
  // declarations
  logic [7:0] win_q [WIN_WORDS];
  logic [3:0] sel_code_q;
  logic [3:0] stat_code_q;
  logic [3:0] ld_code_q;
  logic [7:0] tag0_q;
  logic [7:0] tag1_q;
  logic [3:0] par_q;
  logic       boot_q;
  logic       start_q;
  logic       wr_ok;
  logic       win_hit;
  logic       user_win_wr;
  logic       sel_wr;
  logic [3:0] new_code;
  logic       ld_we;
  logic [3:0] ld_idx;
  logic [7:0] ld_data;
  logic       ld_busy;
  logic       ld_done;
  logic       ld_fail;
  logic [7:0] sel_byte;
  logic [7:0] stat_byte;
  logic [3:0] par_now;

  // ==========================================================
  // write decode
  // lock blocks writes
  assign wr_ok       = reg_wr && !init_complete_lock;
  assign win_hit     = is_range_code(reg_addr[CODE_MSB:CODE_LSB]);
  assign sel_wr      = wr_ok && (reg_addr == ADDR_SEL);
  assign new_code    = reg_wdata[CODE_MSB:CODE_LSB];
  // user writes into the window are held off while a load runs
  assign user_win_wr = wr_ok && win_hit && !ld_busy;
  assign sel_byte    = {sel_code_q, NIB_ZERO};
  assign stat_byte   = {stat_code_q, NIB_ZERO};

  // ==========================================================
  // window select register
  // host stores request code
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_code_q <= SEL_RST[CODE_MSB:CODE_LSB];
    end else if (sel_wr) begin
      sel_code_q <= new_code;           // low nibble reads as zero
    end
  end

  // load launch: after reset and on each range code written
  // only range codes load
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      boot_q    <= 1'b1;
      start_q   <= 1'b0;
      ld_code_q <= SEL_RST[CODE_MSB:CODE_LSB];
    end else begin
      boot_q  <= 1'b0;
      start_q <= 1'b0;
      if (boot_q) begin
        start_q <= 1'b1;
      end else if (sel_wr && is_range_code(new_code)) begin
        start_q   <= 1'b1;
        ld_code_q <= new_code;
      end
    end
  end

  // ==========================================================
  // otp loader
  owt_otp_loader u_loader (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .start      (start_q),
    .code       (ld_code_q),
    .otp_rdata  (otp_rdata),
    .otp_rvalid (otp_rvalid),
    .otp_addr_q (otp_addr_q),
    .otp_rd_q   (otp_rd_q),
    .win_we     (ld_we),
    .win_idx    (ld_idx),
    .win_data   (ld_data),
    .busy       (ld_busy),
    .done       (ld_done),
    .fail       (ld_fail)
  );

  // ==========================================================
  // window status register, hardware-written only
  // no host write path
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_code_q <= STAT_RST[CODE_MSB:CODE_LSB];
    end else if (start_q) begin
      stat_code_q <= CODE_LOAD;
    end else if (ld_done) begin
      stat_code_q <= ld_code_q;
    end else if (user_win_wr) begin
      stat_code_q <= CODE_OVERWR;
    end
  end

  // busy flag, also set at the launch cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      load_busy_q <= 1'b0;
    end else begin
      load_busy_q <= start_q || (ld_busy && !ld_done && !ld_fail);
    end
  end

  // ==========================================================
  // shared window
  // sixteen shared words
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < WIN_WORDS; i++) begin
        win_q[i] <= BYTE_ZERO;
      end
    end else if (ld_we) begin
      win_q[ld_idx] <= ld_data;
    end else if (user_win_wr) begin
      win_q[reg_addr[3:0]] <= reg_wdata;
    end
  end

  // ==========================================================
  // source tag registers
  // tag registers writable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tag0_q <= TAG_RST;
      tag1_q <= TAG_RST;
    end else if (wr_ok) begin
      if (reg_addr == ADDR_TAG0) begin
        tag0_q <= reg_wdata;
      end
      if (reg_addr == ADDR_TAG1) begin
        tag1_q <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // array error detection: parity stored beside select, status and both tag registers
  assign par_now = {par8(tag1_q), par8(tag0_q), par8(stat_byte), par8(sel_byte)};

  // reference parity follows every legitimate update
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      par_q <= {par8(TAG_RST), par8(TAG_RST), par8(STAT_RST), par8(SEL_RST)};
    end else begin
      if (sel_wr) begin
        par_q[0] <= par8({new_code, NIB_ZERO});
      end
      if (start_q) begin
        par_q[1] <= par8({CODE_LOAD, NIB_ZERO});
      end else if (ld_done) begin
        par_q[1] <= par8({ld_code_q, NIB_ZERO});
      end else if (user_win_wr) begin
        par_q[1] <= par8({CODE_OVERWR, NIB_ZERO});
      end
      if (wr_ok && reg_addr == ADDR_TAG0) begin
        par_q[2] <= par8(reg_wdata);
      end
      if (wr_ok && reg_addr == ADDR_TAG1) begin
        par_q[3] <= par8(reg_wdata);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      array_err_q <= 1'b0;
    end else if (par_now != par_q) begin
      array_err_q <= 1'b1;              // sticky until reset
    end
  end

  // ==========================================================
  // read path
  // low nibble picks word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_q <= BYTE_ZERO;
    end else if (reg_rd) begin
      if (win_hit) begin
        reg_rdata_q <= win_q[reg_addr[3:0]];
      end else begin
        case (reg_addr)
          ADDR_SEL:  reg_rdata_q <= sel_byte;
          ADDR_STAT: reg_rdata_q <= stat_byte;
          ADDR_TAG0: reg_rdata_q <= tag0_q;
          ADDR_TAG1: reg_rdata_q <= tag1_q;
          default:   reg_rdata_q <= BYTE_ZERO;
        endcase
      end
    end
  end

  // ==========================================================
  // tag channel routing in spi mode
  always_ff @(posedge ref_clk) begin
    if (rst || !spi_mode) begin
      tag0_data_q <= '0;
      tag1_data_q <= '0;
      tag0_id_q   <= NIB_ZERO;
      tag1_id_q   <= NIB_ZERO;
      tag0_err_q  <= 1'b0;
      tag1_err_q  <= 1'b0;
    end else begin
      tag0_id_q <= tag0_q[TAG_ID_MSB:0];
      tag1_id_q <= tag1_q[TAG_ID_MSB:0];
      tag0_data_q <= tag0_q[TAG_EN_BIT] ? sensor_result_zero : '0;
      tag1_data_q <= tag1_q[TAG_EN_BIT] ? sensor_result_one : '0;
      tag0_err_q  <= !tag0_q[TAG_EN_BIT];
      tag1_err_q  <= !tag1_q[TAG_EN_BIT];
    end
  end

  // ==========================================================
  // read wrap-around control in i2c mode
  // enables drive wrap
  always_ff @(posedge ref_clk) begin
    if (rst || spi_mode) begin
      wrap_en0_q <= 1'b0;
      wrap_en1_q <= 1'b0;
    end else begin
      wrap_en0_q <= tag0_q[TAG_EN_BIT];
      wrap_en1_q <= tag1_q[TAG_EN_BIT];
    end
  end

  initial begin
    if (RESULT_W < 1 || RESULT_W > 32) begin
      $error("RESULT_W out of range");
    end
  end

endmodule

`default_nettype wire
